/* File: include/pit_params.svh */
// constants of the periodic interrupt timer with watchdog
// assumes a 32-bit register port with byte addresses; include by bare name
// Notes on behaviour
// - two independent counters, both running from the peripheral system clock
// - each counter starts on its own and has its own prescale compare value
// - four comparators match against the counters and raise periodic interrupts
// - after each match the comparator advances by itself; period set once
// - two captures, each triggered by any of six audio-port dma events
// - watchdog is off after reset and cannot reset until enabled
// - enabled watchdog reaching zero without service resets the processor
// - on a match the paired increment value is added to the compare value
// - capture latches both free-running and prescale counts of its counter
// - preload value is the start point of the watchdog down-counter
// - configuration register holds two three-bit capture source select fields
`ifndef PIT_PARAMS_SVH
`define PIT_PARAMS_SVH

`define PIT_CFG_BASE 32'h4000_0000
`define PIT_BASE 32'h4200_0000
`define PIT_OFF_CFG 32'h0000_0014
`define PIT_OFF_GCTRL 32'h0000_0000
`define PIT_OFF_CAPCTRL 32'h0000_0008
`define PIT_OFF_COMPCTRL 32'h0000_000C
`define PIT_OFF_FRC0 32'h0000_0010
`define PIT_OFF_UC0 32'h0000_0014
`define PIT_OFF_CPUC0 32'h0000_0018
`define PIT_OFF_CAFRC0 32'h0000_0020
`define PIT_OFF_CAUC0 32'h0000_0024
`define PIT_CNT_STRIDE 32'h0000_0020
`define PIT_OFF_COMP0 32'h0000_0050
`define PIT_COMP_STRIDE 32'h0000_0008
`define PIT_OFF_SETINT 32'h0000_0080
`define PIT_OFF_CLRINT 32'h0000_0084
`define PIT_OFF_INTFLAG 32'h0000_0088
`define PIT_OFF_WDCTRL 32'h0000_0090
`define PIT_OFF_WDPRLD 32'h0000_0094
`define PIT_OFF_WDSTAT 32'h0000_0098
`define PIT_OFF_WDKEY 32'h0000_009C
`define PIT_OFF_WDCNT 32'h0000_00A0

`define PIT_SRC0_LSB 0
`define PIT_SRC1_LSB 4
`define PIT_CAPSEL_W 3
`define PIT_COMPSEL_STRIDE 4
`define PIT_INT_CAP_LSB 4

`define PIT_KEY_ONE 16'hE51A
`define PIT_KEY_TWO 16'hA35C
`define PIT_WDPRLD_RST 32'h00FF_FFFF
`define PIT_CPUC_RST 32'h0000_0000

`endif

/* File: include/pit_pkg.sv */
// types shared by the periodic interrupt timer files
// assumes nothing beyond a SystemVerilog compiler
package pit_pkg;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pit_bus_t;

  typedef struct packed {
    logic [31:0] frc;
    logic [31:0] uc;
  } pit_cap_t;

  typedef enum logic [0:0] {
    PIT_KEY_IDLE,
    PIT_KEY_ARMED
  } pit_key_t;
endpackage

/* File: logic/pit_counter.sv */
// one prescaled free-running counter pair
// assumes run and the compare value come from the register file
`timescale 1ns/1ps
`include "pit_params.svh"
module pit_counter #(
  parameter int W = 32
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic run,
  input wire logic [W-1:0] cpuc,
  output logic [W-1:0] frc_r,
  output logic [W-1:0] uc_r,
  output logic step_r
);
  initial begin
    if (W < 2) $error("pit_counter width too small");
  end

  // prescale wraps on reaching its compare value, and the free-running count steps on that same edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      uc_r <= '0;
      frc_r <= '0;
      step_r <= 1'b0;
    end else if (ce) begin
      step_r <= 1'b0;
      if (run) begin
        if (uc_r == cpuc) begin
          uc_r <= '0;
          frc_r <= frc_r + 1'b1;
          step_r <= 1'b1;
        end else begin
          uc_r <= uc_r + 1'b1;
        end
      end
    end
  end

  // a step held over a frozen stretch is not a new step, so only enabled edges are judged
  a_prescale_step: assert property (@(posedge clock) disable iff (rst)
    step_r && $past(ce) |-> $past(run) && frc_r == $past(frc_r) + 1'b1)
    else $error("free-running step without prescale wrap");
endmodule

/* File: logic/pit_top.sv */
// periodic interrupt timer: two counters, four comparators, two captures, watchdog
// assumes a single clock, a strobe register port and one-cycle dma event pulses
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "pit_params.svh"
module pit_top #(
  parameter int CNT_W = 32,
  parameter int WD_W = 32,
  parameter int NCOMP = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire pit_pkg::pit_bus_t bus,
  output logic [31:0] rdata_r,
  input wire logic [5:0] dma_event,
  output logic irq,
  output logic cpu_reset_req_r
);
  import pit_pkg::*;

  localparam int NFLAG = NCOMP + 2;

  initial begin
    if (CNT_W > 32 || CNT_W < 2) $error("pit_top counter width out of range");
    if (WD_W > 32 || WD_W < 2) $error("pit_top watchdog width out of range");
    if (NCOMP != 4) $error("pit_top supports exactly four comparators");
  end

  //////////////////////////////////////////////////////////////////////////////
  // register state
  logic [1:0] run_r;
  logic [1:0] capctrl_r;
  logic [NCOMP-1:0] compsel_r;
  logic [CNT_W-1:0] cpuc_r [2];
  logic [CNT_W-1:0] comp_r [NCOMP];
  logic [CNT_W-1:0] udcp_r [NCOMP];
  logic [`PIT_CAPSEL_W-1:0] capsel_r [2];
  pit_cap_t cap_r [2];
  logic [NFLAG-1:0] flag_r;
  logic [NFLAG-1:0] inten_r;
  logic wd_en_r;
  logic [WD_W-1:0] wd_prld_r;
  logic [WD_W-1:0] wd_cnt_r;
  logic wd_keyerr_r;
  pit_key_t key_r;

  logic [CNT_W-1:0] frc [2];
  logic [CNT_W-1:0] uc [2];
  logic [1:0] step;
  logic [NCOMP-1:0] match;
  logic [1:0] cap_ev;
  logic [1:0] cap_hit;
  logic [NFLAG-1:0] set_ev;
  logic key_service;
  logic wd_expire;

  wire logic in_pit = bus.addr[31:8] == `PIT_BASE >> 8;
  wire logic [7:0] off = bus.addr[7:0];
  wire logic wr = ce && bus.wr && in_pit;
  wire logic wr_cfg = ce && bus.wr && bus.addr == (`PIT_CFG_BASE | `PIT_OFF_CFG);

  //////////////////////////////////////////////////////////////////////////////
  // counters share one clock and one enable
  for (genvar g = 0; g < 2; g++) begin : g_cnt
    pit_counter #(.W(CNT_W)) u_cnt (
      .clock(clock),
      .rst(rst),
      .ce(ce),
      .run(run_r[g]),
      .cpuc(cpuc_r[g]),
      .frc_r(frc[g]),
      .uc_r(uc[g]),
      .step_r(step[g])
    );
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      run_r <= 2'h0;
      capctrl_r <= 2'h0;
      compsel_r <= '0;
      cpuc_r[0] <= CNT_W'(`PIT_CPUC_RST);
      cpuc_r[1] <= CNT_W'(`PIT_CPUC_RST);
    end else if (wr) begin
      case (off)
        `PIT_OFF_GCTRL: run_r <= bus.wdata[1:0];
        `PIT_OFF_CAPCTRL: capctrl_r <= bus.wdata[1:0];
        `PIT_OFF_COMPCTRL: begin
          for (int i = 0; i < NCOMP; i++) begin
            compsel_r[i] <= bus.wdata[i*`PIT_COMPSEL_STRIDE];
          end
        end
        `PIT_OFF_CPUC0: cpuc_r[0] <= bus.wdata[CNT_W-1:0];
        (`PIT_OFF_CPUC0 + `PIT_CNT_STRIDE): cpuc_r[1] <= bus.wdata[CNT_W-1:0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // comparators: match only on the step that reaches the value, so one match per hit
  always_comb begin
    for (int i = 0; i < NCOMP; i++) begin
      match[i] = ce && step[compsel_r[i]] && frc[compsel_r[i]] == comp_r[i];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NCOMP; i++) begin
        comp_r[i] <= '0;
        udcp_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NCOMP; i++) begin
        if (wr && off == 8'(`PIT_OFF_COMP0 + i * `PIT_COMP_STRIDE)) begin
          comp_r[i] <= bus.wdata[CNT_W-1:0];
        end else if (match[i]) begin
          comp_r[i] <= comp_r[i] + udcp_r[i];
        end
        if (wr && off == 8'(`PIT_OFF_COMP0 + i * `PIT_COMP_STRIDE + 4)) begin
          udcp_r[i] <= bus.wdata[CNT_W-1:0];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // captures: source selects index the six dma events, codes above five are idle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      capsel_r[0] <= '0;
      capsel_r[1] <= '0;
    end else if (wr_cfg) begin
      capsel_r[0] <= bus.wdata[`PIT_SRC0_LSB +: `PIT_CAPSEL_W];
      capsel_r[1] <= bus.wdata[`PIT_SRC1_LSB +: `PIT_CAPSEL_W];
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      cap_ev[i] = ce && capsel_r[i] < 3'h6 && dma_event[capsel_r[i]];
    end
    for (int i = 0; i < 2; i++) begin
      cap_hit[i] = cap_ev[capctrl_r[i]];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cap_r[0] <= '0;
      cap_r[1] <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (cap_hit[i]) begin
          cap_r[i].frc <= 32'(frc[i]);
          cap_r[i].uc <= 32'(uc[i]);
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky flags, set beats a write-one clear in the same cycle
  assign set_ev = {cap_hit, match};

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flag_r <= '0;
      inten_r <= '0;
    end else begin
      if (wr && off == `PIT_OFF_INTFLAG) begin
        flag_r <= (flag_r & ~bus.wdata[NFLAG-1:0]) | set_ev;
      end else begin
        flag_r <= flag_r | set_ev;
      end
      if (wr && off == `PIT_OFF_SETINT) begin
        inten_r <= inten_r | bus.wdata[NFLAG-1:0];
      end else if (wr && off == `PIT_OFF_CLRINT) begin
        inten_r <= inten_r & ~bus.wdata[NFLAG-1:0];
      end
    end
  end

  assign irq = |(flag_r & inten_r);

  //////////////////////////////////////////////////////////////////////////////
  // watchdog: enable is one-way, only reset turns it off again
  always_comb begin
    key_service = wr && off == `PIT_OFF_WDKEY && key_r == PIT_KEY_ARMED
      && bus.wdata[15:0] == `PIT_KEY_TWO;
    wd_expire = ce && wd_en_r && wd_cnt_r == '0 && !key_service;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      key_r <= PIT_KEY_IDLE;
      wd_keyerr_r <= 1'b0;
    end else if (wr && off == `PIT_OFF_WDKEY) begin
      case (key_r)
        PIT_KEY_IDLE: begin
          key_r <= bus.wdata[15:0] == `PIT_KEY_ONE ? PIT_KEY_ARMED : PIT_KEY_IDLE;
          if (bus.wdata[15:0] != `PIT_KEY_ONE) wd_keyerr_r <= 1'b1;
        end
        PIT_KEY_ARMED: begin
          key_r <= bus.wdata[15:0] == `PIT_KEY_ONE ? PIT_KEY_ARMED : PIT_KEY_IDLE;
          if (bus.wdata[15:0] != `PIT_KEY_TWO && bus.wdata[15:0] != `PIT_KEY_ONE) begin
            wd_keyerr_r <= 1'b1;
          end
        end
        default: key_r <= PIT_KEY_IDLE;
      endcase
    end else if (wr && off == `PIT_OFF_WDSTAT && bus.wdata[1]) begin
      wd_keyerr_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wd_en_r <= 1'b0;
      wd_prld_r <= WD_W'(`PIT_WDPRLD_RST);
      wd_cnt_r <= WD_W'(`PIT_WDPRLD_RST);
      cpu_reset_req_r <= 1'b0;
    end else begin
      if (wr && off == `PIT_OFF_WDPRLD) wd_prld_r <= bus.wdata[WD_W-1:0];
      if (!wd_en_r) begin
        if (wr && off == `PIT_OFF_WDCTRL && bus.wdata[0]) begin
          wd_en_r <= 1'b1;
          wd_cnt_r <= wd_prld_r;
        end
      end else if (key_service) begin
        wd_cnt_r <= wd_prld_r;
      end else if (ce && wd_cnt_r != '0) begin
        wd_cnt_r <= wd_cnt_r - 1'b1;
      end
      if (wd_expire) cpu_reset_req_r <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read port: data in the cycle after the strobe, zero for unmapped addresses
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (ce) begin
      rdata_r <= 32'h0000_0000;
      if (bus.rd && bus.addr == (`PIT_CFG_BASE | `PIT_OFF_CFG)) begin
        rdata_r[`PIT_SRC0_LSB +: `PIT_CAPSEL_W] <= capsel_r[0];
        rdata_r[`PIT_SRC1_LSB +: `PIT_CAPSEL_W] <= capsel_r[1];
      end else if (bus.rd && in_pit) begin
        case (off)
          `PIT_OFF_GCTRL: rdata_r[1:0] <= run_r;
          `PIT_OFF_CAPCTRL: rdata_r[1:0] <= capctrl_r;
          `PIT_OFF_COMPCTRL: begin
            for (int i = 0; i < NCOMP; i++) begin
              rdata_r[i*`PIT_COMPSEL_STRIDE] <= compsel_r[i];
            end
          end
          `PIT_OFF_FRC0: rdata_r <= 32'(frc[0]);
          `PIT_OFF_UC0: rdata_r <= 32'(uc[0]);
          `PIT_OFF_CPUC0: rdata_r <= 32'(cpuc_r[0]);
          `PIT_OFF_CAFRC0: rdata_r <= cap_r[0].frc;
          `PIT_OFF_CAUC0: rdata_r <= cap_r[0].uc;
          (`PIT_OFF_FRC0 + `PIT_CNT_STRIDE): rdata_r <= 32'(frc[1]);
          (`PIT_OFF_UC0 + `PIT_CNT_STRIDE): rdata_r <= 32'(uc[1]);
          (`PIT_OFF_CPUC0 + `PIT_CNT_STRIDE): rdata_r <= 32'(cpuc_r[1]);
          (`PIT_OFF_CAFRC0 + `PIT_CNT_STRIDE): rdata_r <= cap_r[1].frc;
          (`PIT_OFF_CAUC0 + `PIT_CNT_STRIDE): rdata_r <= cap_r[1].uc;
          `PIT_OFF_COMP0: rdata_r <= 32'(comp_r[0]);
          `PIT_OFF_COMP0 + 32'h4: rdata_r <= 32'(udcp_r[0]);
          `PIT_OFF_COMP0 + 32'h8: rdata_r <= 32'(comp_r[1]);
          `PIT_OFF_COMP0 + 32'hC: rdata_r <= 32'(udcp_r[1]);
          `PIT_OFF_COMP0 + 32'h10: rdata_r <= 32'(comp_r[2]);
          `PIT_OFF_COMP0 + 32'h14: rdata_r <= 32'(udcp_r[2]);
          `PIT_OFF_COMP0 + 32'h18: rdata_r <= 32'(comp_r[3]);
          `PIT_OFF_COMP0 + 32'h1C: rdata_r <= 32'(udcp_r[3]);
          `PIT_OFF_SETINT: rdata_r[NFLAG-1:0] <= inten_r;
          `PIT_OFF_CLRINT: rdata_r[NFLAG-1:0] <= inten_r;
          `PIT_OFF_INTFLAG: rdata_r[NFLAG-1:0] <= flag_r;
          `PIT_OFF_WDCTRL: rdata_r[0] <= wd_en_r;
          `PIT_OFF_WDPRLD: rdata_r <= 32'(wd_prld_r);
          `PIT_OFF_WDSTAT: rdata_r[1:0] <= {wd_keyerr_r, key_r == PIT_KEY_ARMED};
          `PIT_OFF_WDCNT: rdata_r <= 32'(wd_cnt_r);
          default: ;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_key_pair;
    key_r == PIT_KEY_ARMED && wr && off == `PIT_OFF_WDKEY
      && bus.wdata[15:0] == `PIT_KEY_TWO;
  endsequence

  a_cnt_indep: assert property (@(posedge clock) disable iff (rst)
    step[0] |-> $past(run_r[0]))
    else $error("counter 0 stepped while stopped");
  a_stop_hold: assert property (@(posedge clock) disable iff (rst)
    !run_r[1] && !$past(run_r[1]) |-> $stable(frc[1]))
    else $error("stopped counter 1 moved");
  a_match_flag: assert property (@(posedge clock) disable iff (rst)
    match[0] |=> flag_r[0])
    else $error("compare match did not raise its flag");
  a_comp_advance: assert property (@(posedge clock) disable iff (rst)
    match[2] && !(wr && off == `PIT_OFF_COMP0 + 32'h10)
    |=> comp_r[2] == $past(comp_r[2]) + $past(udcp_r[2]))
    else $error("compare 2 not advanced by its increment");
  a_cap_latch: assert property (@(posedge clock) disable iff (rst)
    cap_hit[1] |=> cap_r[1].frc == 32'($past(frc[1])) && cap_r[1].uc == 32'($past(uc[1])))
    else $error("capture 1 missed the counter values");
  a_wd_off: assert property (@(posedge clock) disable iff (rst)
    !wd_en_r |=> !cpu_reset_req_r || $past(cpu_reset_req_r))
    else $error("reset request while watchdog disabled");
  a_wd_expire: assert property (@(posedge clock) disable iff (rst)
    wd_en_r && ce && wd_cnt_r == '0 && !key_service ##1 1 |-> cpu_reset_req_r)
    else $error("watchdog zero without processor reset");
  a_wd_service: assert property (@(posedge clock) disable iff (rst)
    (wd_en_r and s_key_pair) |=> wd_cnt_r == $past(wd_prld_r) && key_r == PIT_KEY_IDLE)
    else $error("key pair did not reload watchdog");
  a_wd_count: assert property (@(posedge clock) disable iff (rst)
    wd_en_r && ce && !key_service && wd_cnt_r != '0
    |=> wd_cnt_r == $past(wd_cnt_r) - 1'b1)
    else $error("watchdog did not count down");
  a_flag_set_win: assert property (@(posedge clock) disable iff (rst)
    set_ev[4] |=> flag_r[4])
    else $error("capture flag lost");
endmodule

/* File: dv/tb_pit_top.sv */
// self-checking bench for the periodic interrupt timer with watchdog
// assumes pit_top with its strobe register port and one 200 MHz clock
`timescale 1ns/1ps
`include "pit_params.svh"
module tb_pit_top;
  import pit_pkg::*;
  typedef struct {string nm; logic [31:0] exp; logic [31:0] msk;} pit_tb_note_t;
  localparam logic [31:0] base_a = `PIT_BASE;
  localparam logic [31:0] cfg_a = `PIT_CFG_BASE + `PIT_OFF_CFG;
  logic clock;
  logic rst;
  logic ce;
  logic irq;
  logic cpu_reset_req_r;
  logic [31:0] rdata_r;
  logic [5:0] dma_event;
  logic rd_seen = 1'b0;
  pit_bus_t bus;
  pit_tb_note_t notes[$];
  pit_tb_note_t n;
  int err_count;
  int check_count;
  int unsigned inc[4];
  int k;

  pit_top pit_top_inst (.clock(clock), .rst(rst), .ce(ce), .bus(bus), .rdata_r(rdata_r),
    .dma_event(dma_event), .irq(irq), .cpu_reset_req_r(cpu_reset_req_r));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_pin(input string nm, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %b seen %b", nm, exp, got);
    end
  endtask

  // read data stands only in the cycle after the strobe, so it is taken at the next edge
  always @(posedge clock) begin
    if (rd_seen) begin
      if (notes.size() == 0) begin
        err_count++;
        $display("mismatch read data expected none seen %h", rdata_r);
      end else begin
        n = notes.pop_front();
        chk(n.nm, n.exp & n.msk, rdata_r & n.msk);
      end
    end
    rd_seen <= bus.rd;
  end

  ////////////////////////////////////////////////////////////////
  // bus tasks leave the strobe up so accesses can run back to back; idle drops it
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
  endtask

  task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFF_FFFF);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    notes.push_back('{nm, e, m});
    @(posedge clock);
  endtask

  task automatic idle(input int c);
    bus <= '{addr: 32'h0, wdata: 32'h0, wr: 1'b0, rd: 1'b0};
    repeat (c) @(posedge clock);
  endtask

  // one-cycle event, then one more edge so the flag has landed before a read
  task automatic pulse(input int line);
    bus <= '{addr: 32'h0, wdata: 32'h0, wr: 1'b0, rd: 1'b0};
    dma_event <= 6'(1 << line);
    @(posedge clock);
    dma_event <= 6'h00;
    @(posedge clock);
  endtask

  task automatic serve();
    wr(base_a + `PIT_OFF_WDKEY, 32'h0000_E51A);
    wr(base_a + `PIT_OFF_WDKEY, 32'h0000_A35C);
    idle(1);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    dma_event = 6'h00;
    bus = '{addr: 32'h0, wdata: 32'h0, wr: 1'b0, rd: 1'b0};
    err_count = 0;
    check_count = 0;
    void'($urandom(32'h8825));
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd("preload", base_a + `PIT_OFF_WDPRLD, 32'h00FF_FFFF);
    rd("config", cfg_a, 32'h0);
    rd("unmapped", base_a + 32'h0000_0004, 32'h0);
    idle(200);
    chk_pin("reset request", 1'b0, cpu_reset_req_r);
    chk_pin("irq at reset", 1'b0, irq);
    // all four comparators on counter 0, period of 4 cycles per count
    wr(base_a + `PIT_OFF_CPUC0, 32'h3);
    wr(base_a + `PIT_OFF_CPUC0 + `PIT_CNT_STRIDE, 32'h1);
    wr(base_a + `PIT_OFF_COMPCTRL, 32'h0);
    for (k = 0; k < 4; k++) begin
      inc[k] = $urandom_range(11, 4);
      wr(base_a + `PIT_OFF_COMP0 + 32'(k * 8), 32'h2);
      wr(base_a + `PIT_OFF_COMP0 + 32'(k * 8 + 4), inc[k]);
    end
    wr(base_a + `PIT_OFF_SETINT, 32'h1);
    wr(base_a + `PIT_OFF_GCTRL, 32'h1);
    idle(1);
    k = 0;
    while (irq !== 1'b1 && k < 100) begin
      @(posedge clock);
      k++;
    end
    chk_pin("compare irq", 1'b1, irq);
    for (k = 0; k < 4; k++) begin
      rd("compare", base_a + `PIT_OFF_COMP0 + 32'(k * 8), 32'h2 + inc[k]);
    end
    rd("flags", base_a + `PIT_OFF_INTFLAG, 32'hF, 32'h3F);
    rd("idle counter", base_a + `PIT_OFF_FRC0 + `PIT_CNT_STRIDE, 32'h0);
    wr(base_a + `PIT_OFF_CLRINT, 32'h1);
    wr(base_a + `PIT_OFF_INTFLAG, 32'hF);
    idle(2);
    chk_pin("irq cleared", 1'b0, irq);
    // the next match happens while masked: flag sticks, irq waits for the enable
    idle(70);
    rd("masked flag", base_a + `PIT_OFF_INTFLAG, 32'h1, 32'h1);
    idle(2);
    chk_pin("masked irq", 1'b0, irq);
    wr(base_a + `PIT_OFF_SETINT, 32'h1);
    idle(2);
    chk_pin("unmasked irq", 1'b1, irq);
    wr(base_a + `PIT_OFF_GCTRL, 32'h0);
    wr(base_a + `PIT_OFF_CLRINT, 32'hF);
    wr(base_a + `PIT_OFF_INTFLAG, 32'h3F);
    idle(3);
    // every event line as source, unit 0 then unit 1
    wr(base_a + `PIT_OFF_CAPCTRL, 32'h2);
    for (k = 0; k < 6; k++) begin
      wr(cfg_a, 32'h70 | 32'(k));
      rd("config", cfg_a, 32'h70 | 32'(k));
      pulse((k + 1) % 6);
      rd("wrong line", base_a + `PIT_OFF_INTFLAG, 32'h0, 32'h30);
      pulse(k);
      rd("capture 0", base_a + `PIT_OFF_INTFLAG, 32'h10, 32'h30);
      wr(cfg_a, 32'(k << 4) | 32'h7);
      wr(base_a + `PIT_OFF_INTFLAG, 32'h30);
      pulse(k);
      rd("capture 1", base_a + `PIT_OFF_INTFLAG, 32'h20, 32'h30);
      wr(base_a + `PIT_OFF_INTFLAG, 32'h30);
    end
    // counter 1 starts here; after three idle cycles it stands at free 1, prescale 1
    wr(base_a + `PIT_OFF_GCTRL, 32'h2);
    idle(3);
    pulse(5);
    rd("captured free", base_a + `PIT_OFF_CAFRC0 + `PIT_CNT_STRIDE, 32'h1);
    rd("captured pre", base_a + `PIT_OFF_CAUC0 + `PIT_CNT_STRIDE, 32'h1);
    // swapped capture control: unit 0 now follows capture event 1
    wr(base_a + `PIT_OFF_INTFLAG, 32'h30);
    wr(base_a + `PIT_OFF_CAPCTRL, 32'h1);
    pulse(5);
    rd("swapped capture", base_a + `PIT_OFF_INTFLAG, 32'h10, 32'h30);
    wr(base_a + `PIT_OFF_INTFLAG, 32'h30);
    // an event while the clock enable is low must be dropped
    ce <= 1'b0;
    pulse(5);
    ce <= 1'b1;
    rd("frozen capture", base_a + `PIT_OFF_INTFLAG, 32'h0, 32'h30);
    // comparator 3 moved onto counter 1, which is still running
    wr(base_a + `PIT_OFF_COMP0 + 32'h18, 32'h40);
    wr(base_a + `PIT_OFF_COMPCTRL, 32'h0000_1000);
    wr(base_a + `PIT_OFF_SETINT, 32'h8);
    idle(1);
    k = 0;
    while (irq !== 1'b1 && k < 200) begin
      @(posedge clock);
      k++;
    end
    chk_pin("counter 1 compare", 1'b1, irq);
    wr(base_a + `PIT_OFF_CLRINT, 32'h8);
    wr(base_a + `PIT_OFF_INTFLAG, 32'h8);
    // a 40-cycle watchdog, kept alive well past its span by the key pair
    wr(base_a + `PIT_OFF_WDPRLD, 32'h0000_0028);
    wr(base_a + `PIT_OFF_WDCTRL, 32'h1);
    for (k = 0; k < 6; k++) begin
      idle(25);
      serve();
    end
    chk_pin("serviced", 1'b0, cpu_reset_req_r);
    wr(base_a + `PIT_OFF_WDKEY, 32'h0000_A35C);
    wr(base_a + `PIT_OFF_WDKEY, 32'h0000_E51A);
    rd("key status", base_a + `PIT_OFF_WDSTAT, 32'h3, 32'h3);
    idle(20);
    chk_pin("not yet expired", 1'b0, cpu_reset_req_r);
    k = 0;
    while (cpu_reset_req_r !== 1'b1 && k < 40) begin
      @(posedge clock);
      k++;
    end
    chk_pin("expired", 1'b1, cpu_reset_req_r);
    idle(3);
    report_and_stop();
  end
endmodule
